// ===== pattern_seq_pkg.sv
package pattern_seq_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DEPTH         = 1024;
  localparam int unsigned EXP_DATA_W    = 32;
  localparam int unsigned EXP_ADDR_W    = 11;
  localparam int unsigned MAX_EXP       = 5;
  localparam int unsigned LABELS        = 16;
  localparam int unsigned LABEL_W       = 4;
  localparam int unsigned MAX_STEP_HZ   = 50_000_000;
  localparam int unsigned MASTER_HZ     = 25_000_000;
  localparam int unsigned SKEW_NS       = 5;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SKEW_CYC      = (SKEW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MIN_DIV_SOLO  = (CLK_HZ + MAX_STEP_HZ - 1)
                                          / MAX_STEP_HZ;
  localparam int unsigned MIN_DIV_MAST  = (CLK_HZ + MASTER_HZ - 1)
                                          / MASTER_HZ;
  localparam int unsigned DIV_W         = 8;
  localparam logic [LABEL_W-1:0] ISR_LABEL = 4'hf;
  localparam int unsigned UCODE_W       = 36;

  typedef enum logic [3:0] {
    OP_NEXT   = 4'h0,
    OP_JMP    = 4'h1,
    OP_JZ     = 4'h2,
    OP_JNZ    = 4'h3,
    OP_JEXT   = 4'h4,
    OP_CALL   = 4'h5,
    OP_RET    = 4'h6,
    OP_JZA    = 4'h7,
    OP_JZB    = 4'h8
  } flow_op_t;

  typedef enum logic [1:0] {
    REG_HOLD = 2'h0,
    REG_INC  = 2'h1,
    REG_DEC  = 2'h2,
    REG_LOAD = 2'h3
  } reg_op_t;

  typedef enum logic [1:0] {
    LINK_OFF    = 2'h0,
    LINK_SEQ    = 2'h1,
    LINK_FOLLOW = 2'h3
  } link_mode_t;

  // microcode word layout (msb first)
  typedef struct packed {
    flow_op_t          op;
    logic [LABEL_W-1:0] label;
    reg_op_t           ra_op;
    reg_op_t           rb_op;
    logic              out_sel_reg;
    logic [1:0]        strobe;
    logic              next_page;
    logic              halt;
    logic [DATA_W-1:0] vector;
    logic [2:0]        pad;
  } ucode_t;
endpackage

// ===== exp_link_if.sv
`timescale 1ns/1ps
interface exp_link_if;
  import pattern_seq_pkg::*;
  logic                   step;
  logic                   run;
  link_mode_t             mode;
  logic [ADDR_W-1:0]      vec_addr;
  logic                   page_sel;
  logic                   next_page_request;
  logic [MAX_EXP-1:0]     page_done;

  modport master (
    output step, run, mode, vec_addr, page_sel, next_page_request,
    input  page_done
  );
  modport expansion (
    input  step, run, mode, vec_addr, page_sel, next_page_request,
    output page_done
  );
endinterface

// ===== expansion_pattern.sv
`timescale 1ns/1ps
module expansion_pattern #(
  parameter int unsigned SLOT = 0
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  nrst,
  exp_link_if.expansion                              link,
  input  wire logic [1:0]                            rate_sel,
  input  wire logic                                  repeat_en,
  input  wire logic                                  wr_en,
  input  wire logic [pattern_seq_pkg::EXP_ADDR_W-1:0] wr_addr,
  input  wire logic [pattern_seq_pkg::EXP_DATA_W+7:0] wr_data,
  input  wire logic                                  reload_done,
  output logic      [pattern_seq_pkg::EXP_DATA_W-1:0] data_out,
  output logic      [3:0]                            strobe_out,
  output logic      [3:0]                            clk_out,
  output logic                                       reload_req
);
  import pattern_seq_pkg::*;

  // 32 data, 4 strobes, 4 clock-shape bits per line
  logic [EXP_DATA_W+7:0] mem [0:(1<<EXP_ADDR_W)-1];

  typedef struct packed {
    logic [EXP_ADDR_W-1:0] seq_addr;
    logic [1:0]            prescale;
    logic                  cur_page;
    logic                  done;
    logic [EXP_DATA_W-1:0] data_out;
    logic [3:0]            strobe_out;
    logic [3:0]            clk_out;
    logic                  reload_req;
    logic                  page_done;
  } exp_state_t;

  exp_state_t st;
  exp_state_t next_st;
  logic       tick;
  logic [EXP_ADDR_W-1:0] rd_addr;
  logic [EXP_DATA_W+7:0] rd_word;

  ////////////////////////////////////////////////////////////////////////
  // rate divide and address source
  always_comb begin
    unique case (rate_sel)
      2'h1:    tick = link.step && st.prescale[0];
      2'h2:    tick = link.step && (st.prescale == 2'h3);
      default: tick = link.step;
    endcase
    if (link.mode == LINK_FOLLOW) begin
      rd_addr = {link.page_sel, link.vec_addr};
    end else begin
      rd_addr = st.seq_addr;
    end
    rd_word = mem[rd_addr];
  end

  // page writes from the host; the page under output must not be written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (reload_done) begin
      next_st.reload_req = 1'b0;
      next_st.page_done  = 1'b1;
    end
    if (link.next_page_request && link.mode == LINK_FOLLOW) begin
      next_st.cur_page   = ~st.cur_page;
      next_st.reload_req = 1'b1; // set wins over clear
      next_st.page_done  = 1'b0;
    end
    if (!link.run) begin
      next_st.seq_addr = '0;
      next_st.prescale = 2'h0;
      next_st.done     = 1'b0;
    end else if (link.step) begin
      next_st.prescale = st.prescale + 2'h1;
    end
    if (link.run && tick && !st.done) begin
      next_st.data_out   = rd_word[EXP_DATA_W+7:8];
      next_st.strobe_out = rd_word[7:4];
      next_st.clk_out    = rd_word[3:0];
      if (link.mode == LINK_SEQ) begin
        if (st.seq_addr == EXP_ADDR_W'((1<<EXP_ADDR_W)-1)) begin
          next_st.seq_addr = '0;
          next_st.done     = ~repeat_en;
        end else begin
          next_st.seq_addr = st.seq_addr + 1'b1;
        end
      end
    end
  end

  // state register; page_done is the slot's reload-complete answer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_out            = st.data_out;
  assign strobe_out          = st.strobe_out;
  assign clk_out             = st.clk_out;
  assign reload_req          = st.reload_req;
  assign link.page_done[SLOT] = st.page_done;
endmodule

// ===== pattern_sequencer.sv
`timescale 1ns/1ps
module pattern_sequencer (
  input  wire logic                                clk_sys,
  input  wire logic                                nrst,
  exp_link_if.master                               link,
  input  wire logic                                ext_clk,
  input  wire logic                                ext_clk_sel,
  input  wire logic [pattern_seq_pkg::DIV_W-1:0]   clk_div,
  input  wire logic                                start,
  input  wire logic                                stop,
  input  wire logic                                auto_restart,
  input  wire logic                                split_reg,
  input  wire pattern_seq_pkg::link_mode_t         link_mode,
  input  wire logic [pattern_seq_pkg::MAX_EXP-1:0] exp_present,
  input  wire logic                                ext_jump,
  input  wire logic                                ext_irq,
  input  wire logic [1:0]                          port_skew,
  input  wire logic [pattern_seq_pkg::DATA_W+3:0]  line_skew,
  input  wire logic [pattern_seq_pkg::DATA_W-1:0]  reg_load,
  input  wire logic [pattern_seq_pkg::LABEL_W*16-1:0] label_addr,
  input  wire logic                                uc_wr,
  input  wire logic [pattern_seq_pkg::ADDR_W-1:0]  uc_wr_addr,
  input  wire logic [pattern_seq_pkg::UCODE_W-1:0] uc_wr_data,
  output logic      [pattern_seq_pkg::DATA_W-1:0]  data_out,
  output logic      [1:0]                          clk_out,
  output logic      [1:0]                          strobe_out,
  output logic                                     running,
  output logic                                     sustaining
);
  import pattern_seq_pkg::*;

  // label_addr holds 16 x 4-bit block indices; label slot n points to line
  // label_addr field n times 64, the start of one of 16 blocks of 64 lines
  ucode_t ucode [0:DEPTH-1];

  typedef struct packed {
    logic [1:0]         ext_clk_s;
    logic [1:0]         jump_s;
    logic [1:0]         irq_s;
    logic               ext_clk_prev;
    logic [DIV_W-1:0]   div_cnt;
    logic               run;
    logic [ADDR_W-1:0]  pc;
    logic [ADDR_W-1:0]  step_addr;
    logic [ADDR_W-1:0]  ret_pc;
    logic               in_isr;
    logic [DATA_W-1:0]  ireg;
    logic               jump_latch;
    logic               irq_latch;
    logic               page_sel;
    logic               sustain;
    logic               step;
    logic               npr;
    logic [DATA_W+3:0]  stage0;
    logic [DATA_W+3:0]  stage1;
    logic [DATA_W-1:0]  data_out;
    logic [1:0]         clk_out;
    logic [1:0]         strobe_out;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;
  ucode_t     uc;
  logic [DIV_W-1:0] div_lim;
  logic       tick;
  logic       reg_zero;
  logic       take;
  logic [ADDR_W-1:0] target;
  logic [DATA_W+3:0] word;
  logic [DATA_W+3:0] skewed;

  // label n sits on line (label_addr field n) * (depth / 16); label 15 is the interrupt entry
  function automatic logic [ADDR_W-1:0] label_line(
    input logic [LABEL_W-1:0] idx
  );
    label_line = {label_addr[idx*LABEL_W +: LABEL_W], 6'h00};
  endfunction

  function automatic logic [7:0] reg_step8(input logic [7:0] v,
                                           input reg_op_t op,
                                           input logic [7:0] ld);
    unique case (op)
      REG_INC:  reg_step8 = v + 8'h01;
      REG_DEC:  reg_step8 = v - 8'h01;
      REG_LOAD: reg_step8 = ld;
      default:  reg_step8 = v;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (uc_wr) begin
      ucode[uc_wr_addr] <= ucode_t'(uc_wr_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // step divider; slower floor while mastering expansions
  always_comb begin
    uc = ucode[st.pc];
    div_lim = clk_div;
    if (link_mode != LINK_OFF && clk_div < DIV_W'(MIN_DIV_MAST - 1)) begin
      div_lim = DIV_W'(MIN_DIV_MAST - 1);
    end else if (clk_div < DIV_W'(MIN_DIV_SOLO - 1)) begin
      div_lim = DIV_W'(MIN_DIV_SOLO - 1);
    end
    if (ext_clk_sel) begin
      tick = st.ext_clk_s[1] && !st.ext_clk_prev;
    end else begin
      tick = (st.div_cnt == div_lim);
    end
    reg_zero = (st.ireg == '0);
    unique case (uc.op)
      OP_JMP:  take = 1'b1;
      OP_JZ:   take = reg_zero;
      OP_JNZ:  take = !reg_zero;
      OP_JEXT: take = st.jump_latch;
      OP_CALL: take = !link.page_done[0] || (link.page_done & exp_present)
                      != exp_present;
      OP_RET:  take = 1'b1;
      OP_JZA:  take = split_reg && st.ireg[7:0] == 8'h00;
      OP_JZB:  take = split_reg && st.ireg[15:8] == 8'h00;
      default: take = 1'b0;
    endcase
    target = (uc.op == OP_RET) ? st.ret_pc : label_line(uc.label);
    word = {uc.strobe, 2'b11,
            uc.out_sel_reg ? st.ireg : uc.vector};
    // port/line skew: selected bits take the older stage1 sample, one step late
    skewed = st.stage0;
    for (int i = 0; i < DATA_W + 4; i++) begin
      if (port_skew[i >= DATA_W/2 ? 1 : 0] ^ line_skew[i]) begin
        skewed[i] = st.stage1[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st              = st;
    next_st.ext_clk_s    = {st.ext_clk_s[0], ext_clk};
    next_st.jump_s       = {st.jump_s[0], ext_jump};
    next_st.irq_s        = {st.irq_s[0], ext_irq};
    next_st.ext_clk_prev = st.ext_clk_s[1];
    next_st.div_cnt      = tick ? '0 : st.div_cnt + 1'b1;
    next_st.step         = 1'b0;
    next_st.npr          = 1'b0;
    // sticky external latches; the event wins over the test that clears
    if (tick && st.run && uc.op == OP_JEXT) begin
      next_st.jump_latch = 1'b0;
    end
    if (st.jump_s[1]) begin
      next_st.jump_latch = 1'b1;
      next_st.page_sel   = ~st.page_sel;
    end
    if (st.irq_s[1]) begin
      next_st.irq_latch = 1'b1;
    end
    if (start) begin
      next_st.run    = 1'b1;
      next_st.pc     = '0;
      next_st.in_isr = 1'b0;
    end else if (stop) begin
      next_st.run = 1'b0;
    end else if (tick && st.run) begin
      next_st.step   = 1'b1;
      next_st.npr    = uc.next_page;
      // the cable carries the line being output, not the one fetched next
      next_st.step_addr = st.pc;
      next_st.stage1 = st.stage0;
      next_st.stage0 = word;
      if (split_reg) begin
        next_st.ireg = {reg_step8(st.ireg[15:8], uc.rb_op, reg_load[15:8]),
                        reg_step8(st.ireg[7:0], uc.ra_op, reg_load[7:0])};
      end else begin
        unique case (uc.ra_op)
          REG_INC:  next_st.ireg = st.ireg + 1'b1;
          REG_DEC:  next_st.ireg = st.ireg - 1'b1;
          REG_LOAD: next_st.ireg = reg_load;
          default:  next_st.ireg = st.ireg;
        endcase
      end
      next_st.sustain = (uc.op == OP_CALL) && take;
      if (st.irq_latch && !st.in_isr) begin
        next_st.irq_latch = st.irq_s[1];
        next_st.in_isr    = 1'b1;
        next_st.ret_pc    = st.pc;
        next_st.pc        = label_line(ISR_LABEL);
      end else if (take) begin
        if (uc.op == OP_RET) begin
          next_st.in_isr = 1'b0;
        end
        next_st.pc = target;
      end else if (uc.halt) begin
        next_st.run = 1'b0;
      end else if (st.pc == ADDR_W'(DEPTH - 1)) begin
        next_st.pc  = '0;
        next_st.run = auto_restart;
      end else begin
        next_st.pc = st.pc + 1'b1;
      end
    end
    next_st.data_out   = skewed[DATA_W-1:0];
    next_st.clk_out    = {2{st.step}};
    next_st.strobe_out = skewed[DATA_W+3:DATA_W+2];
  end

  // one register for the whole state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // expansion link, steps only go out while mastering; run, address, page and request always driven (five slots max)
  assign link.step              = st.step && link_mode != LINK_OFF;
  assign link.run               = st.run;
  assign link.mode              = link_mode;
  assign link.vec_addr          = st.step_addr;
  assign link.page_sel          = st.page_sel;
  assign link.next_page_request = st.npr;
  assign data_out               = st.data_out;
  assign clk_out                = st.clk_out;
  assign strobe_out             = st.strobe_out;
  assign running                = st.run;
  assign sustaining             = st.sustain;
endmodule

// ===== pattern_link_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// watches the cable between sequencer and expansion modules
module pattern_link_asserts
  import pattern_seq_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic               step,
  input wire logic               run,
  input wire link_mode_t         mode,
  input wire logic [ADDR_W-1:0]  vec_addr,
  input wire logic               page_sel,
  input wire logic               next_page_request,
  input wire logic [MAX_EXP-1:0] page_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////
  // step timing: one-cycle pulses, slower spacing when driving modules
  property p_step_pulse;
    step |=> !step;
  endproperty
  a_step_pulse: assert property (p_step_pulse)
    else $error("step pulse wider than one cycle");

  property p_master_gap;
    step && mode != LINK_OFF |=> !step [*3];
  endproperty
  a_master_gap: assert property (p_master_gap)
    else $error("steps closer than four cycles while master");

  property p_step_running;
    step |-> run;
  endproperty
  a_step_running: assert property (p_step_running)
    else $error("step issued while not running");

  ////////////////////////////////////////////////////////////////////////
  // the address on the cable only moves with a step or a fresh start
  property p_addr_on_step;
    $changed(vec_addr) |-> step || $past(step) || !$past(run);
  endproperty
  a_addr_on_step: assert property (p_addr_on_step)
    else $error("vector address moved without a step");

  property p_addr_hold;
    step && mode == LINK_FOLLOW |-> ##2 $stable(vec_addr) [*2];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("vector address unstable between steps");

  ////////////////////////////////////////////////////////////////////////
  // page change request is a single pulse issued only while running
  property p_npr_pulse;
    next_page_request |=> !next_page_request;
  endproperty
  a_npr_pulse: assert property (p_npr_pulse)
    else $error("page request wider than one cycle");

  property p_npr_running;
    next_page_request |-> run;
  endproperty
  a_npr_running: assert property (p_npr_running)
    else $error("page request while stopped");

  // everything quiet right after reset, page A selected
  property p_reset_quiet;
    $rose(nrst) |-> !step && !run && !next_page_request && !page_sel;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("link not idle after reset");

  ////////////////////////////////////////////////////////////////////////
  c_seq_step:    cover property (step && mode == LINK_SEQ);
  c_follow_step: cover property (step && mode == LINK_FOLLOW);
  c_page_flip:   cover property ($rose(page_sel));
  c_npr:         cover property (next_page_request);
endmodule

// ===== algorithmic_pattern_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); \
  end \
end

module algorithmic_pattern_sequencer_tb;
  import pattern_seq_pkg::*;
  logic              clk_sys      = 1'b0;
  logic              nrst         = 1'b0;
  logic              start        = 1'b0;
  logic              stop         = 1'b0;
  logic              ext_jump     = 1'b0;
  logic              auto_restart = 1'b0;
  logic              split_reg    = 1'b0;
  link_mode_t        link_mode    = LINK_OFF;
  logic [15:0]       reg_load     = 16'h0;
  logic [63:0]       label_addr   = 64'h10;
  logic              uc_wr        = 1'b0;
  logic [9:0]        uc_wr_addr   = 10'h0;
  logic [35:0]       uc_wr_data   = 36'h0;
  logic              wr_en        = 1'b0;
  logic [10:0]       wr_addr      = 11'h0;
  logic [39:0]       wr_data      = 40'h0;
  logic              reload_done  = 1'b0;
  logic [7:0]        clk_div      = 8'h00;
  logic [4:0]        exp_present  = 5'h01;
  logic [1:0]        port_skew    = 2'h0;
  logic [19:0]       line_skew    = 20'h0;
  logic [1:0]        rate_sel     = 2'h0;
  logic              repeat_en    = 1'b0;
  logic [1:0]        strobe_seen;
  logic              sustaining;
  logic [15:0]       data_out;
  logic [1:0]        clk_out;
  logic              running;
  logic [31:0]       exp_data;
  logic [3:0]        exp_clk;
  logic              reload_req;
  logic [15:0]       vec [1024];
  logic [31:0]       emem [2048];
  logic [17:0]       q_dev [$];
  logic [31:0]       q_exp [$];
  logic [17:0]       e_dev;
  logic [31:0]       e_exp;
  ucode_t            u;
  int                i;
  int                num_errors = 0;
  int                cmp_count  = 0;

  exp_link_if link ();

  // only slot 0 is fitted; the empty slots report nothing
  assign link.page_done[MAX_EXP-1:1] = '0;

  pattern_sequencer i_pattern_sequencer (
    .clk_sys(clk_sys), .nrst(nrst), .link(link), .ext_clk(1'b0),
    .ext_clk_sel(1'b0), .clk_div(clk_div), .start(start), .stop(stop),
    .auto_restart(auto_restart), .split_reg(split_reg),
    .link_mode(link_mode), .exp_present(exp_present),
    .ext_jump(ext_jump), .ext_irq(1'b0), .port_skew(port_skew),
    .line_skew(line_skew), .reg_load(reg_load),
    .label_addr(label_addr), .uc_wr(uc_wr),
    .uc_wr_addr(uc_wr_addr), .uc_wr_data(uc_wr_data),
    .data_out(data_out), .clk_out(clk_out), .strobe_out(strobe_seen),
    .running(running), .sustaining(sustaining));

  expansion_pattern #(.SLOT(0)) i_expansion_pattern (
    .clk_sys(clk_sys), .nrst(nrst), .link(link), .rate_sel(rate_sel),
    .repeat_en(repeat_en), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .reload_done(reload_done), .data_out(exp_data),
    .strobe_out(), .clk_out(exp_clk), .reload_req(reload_req));

  pattern_link_asserts i_pattern_link_asserts (
    .clk_sys(clk_sys), .nrst(nrst), .step(link.step), .run(link.run),
    .mode(link.mode), .vec_addr(link.vec_addr), .page_sel(link.page_sel),
    .next_page_request(link.next_page_request),
    .page_done(link.page_done));

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  // score results on the falling edge, while an output clock pulse is high
  always @(negedge clk_sys) begin
    if (nrst && clk_out[0] === 1'b1) begin
      if (q_dev.size() == 0)
        `CHK("dev_extra", 1'b0, 1'b1)
      else begin
        e_dev = q_dev.pop_front();
        `CHK("dev_data", e_dev, {strobe_seen, data_out})
      end
    end
    // expansion clock bits are held levels, so pace on the device's step
    // pulse; at full rate both ends update on the same edge
    if (nrst && clk_out[0] === 1'b1 && q_exp.size() != 0) begin
      e_exp = q_exp.pop_front();
      `CHK("exp_data", e_exp, exp_data)
    end
  end

  // one-cycle strobe: 0 start, 1 stop, 2 reload done, else ext jump
  task automatic pulse(input int which);
    @(posedge clk_sys);
    case (which)
      0:       start       <= 1'b1;
      1:       stop        <= 1'b1;
      2:       reload_done <= 1'b1;
      default: ext_jump    <= 1'b1;
    endcase
    @(posedge clk_sys);
    start       <= 1'b0;
    stop        <= 1'b0;
    reload_done <= 1'b0;
    ext_jump    <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // note the expected path (jump at line 2 to line 64), run, then stop
  task automatic run_prog(input int n, input link_mode_t m,
                          input logic pg);
    int pc;
    int k;
    q_dev.delete();
    q_exp.delete();
    pc = 0;
    for (k = 0; k < n; k++) begin
      q_dev.push_back({vec[pc][15:14], vec[pc]});
      if (k < 8)
        q_exp.push_back(m == LINK_SEQ ? emem[k] : emem[{pg, pc[9:0]}]);
      pc = (pc == 2) ? 64 : (pc + 1) % 1024;
    end
    link_mode <= m;
    pulse(0);
    k = 0;
    while (q_dev.size() > 3 && k < n * 8 + 100) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("running", 1'b1, running)
    `CHK("dev_left", 1'b1, q_dev.size() <= 3)
    pulse(1);
    repeat (20) @(posedge clk_sys);
    `CHK("exp_left", 1'b1, q_exp.size() == 0)
  endtask

  task print_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: load both memories, then sequential and follow runs
  initial begin
    void'($urandom(32'hf5b0));
    repeat (3) @(posedge clk_sys);
    nrst      <= 1'b1;
    split_reg <= 1'($urandom);
    reg_load  <= 16'($urandom);
    clk_div   <= 8'($urandom_range(5));
    for (i = 0; i < 2048; i++) begin
      emem[i] = $urandom;
      if (i < 1024)
        vec[i] = 16'($urandom);
      u = '0;
      u.op = (i == 2) ? OP_JMP : OP_NEXT;
      u.label = 4'h1;
      u.strobe = vec[i % 1024][15:14];
      u.next_page = (i == 70);
      u.vector = vec[i % 1024];
      @(posedge clk_sys);
      uc_wr <= (i < 1024);
      uc_wr_addr <= i[9:0];
      uc_wr_data <= UCODE_W'(u);
      wr_en <= 1'b1;
      wr_addr <= i[10:0];
      wr_data <= {emem[i], 4'h0, 4'hf};
    end
    @(posedge clk_sys);
    uc_wr <= 1'b0;
    wr_en <= 1'b0;
    run_prog(80, LINK_SEQ, 1'b0);
    // sequential slots run their own program and never swap pages
    `CHK("seq_no_swap", 1'b0, reload_req)
    auto_restart <= 1'b1;
    // long enough to pass line 1023 and wrap back to line 0
    run_prog(1100, LINK_FOLLOW, 1'b0);
    `CHK("reload_req", 1'b1, reload_req)
    pulse(2);
    repeat (5) @(posedge clk_sys);
    `CHK("reload_clr", 1'b0, reload_req)
    `CHK("page_done", 1'b1, link.page_done[0])
    `CHK("sustain", 1'b0, sustaining)
    pulse(3);
    repeat (6) @(posedge clk_sys);
    `CHK("page_sel", 1'b1, link.page_sel)
    run_prog(20, LINK_FOLLOW, 1'b1);
    print_verdict();
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
endmodule
